// File: hw/npr_map.svh
// constants for the nibble pair read instruction decoder
`ifndef NPR_MAP_SVH
`define NPR_MAP_SVH
`define NPR_OP_TIMER4      10'h273
`define NPR_OP_CONV        10'h279
`define NPR_OP_HOLD        10'h02a
`define NPR_MODE_BIT       3
`define NPR_HI_LSB_T4      4
`define NPR_LO_LSB_T4      0
`define NPR_HI_LSB_CONV    6
`define NPR_LO_LSB_CONV    2
`define NPR_HI_LSB_CMP     4
`define NPR_LO_LSB_CMP     0
`define NPR_HI_LSB_HOLD    4
`define NPR_LO_LSB_HOLD    0
`define NPR_NIB_RESET      4'h0
`endif

// File: hw/npr_pkg.sv
// types for the nibble pair read instruction decoder
package npr_pkg;
	typedef enum logic [3:0] {
		NPR_SEL_NONE = 4'b0001,
		NPR_SEL_T4   = 4'b0010,
		NPR_SEL_CONV = 4'b0100,
		NPR_SEL_HOLD = 4'b1000
	} npr_sel_t;
	typedef struct packed {
		logic       we;
		logic [3:0] upper;
		logic [3:0] acc;
	} npr_wr_t;
endpackage

// File: hw/npr_decode.sv
// opcode decoder for the three read instructions
`timescale 1ns/100ps
`default_nettype none
`include "npr_map.svh"
module npr_decode #(
	parameter int OPW = 10
) (
	input  wire logic [OPW-1:0]    i_op,  // instruction word
	input  wire logic              i_vld, // word is valid this cycle
	output var  npr_pkg::npr_sel_t o_sel  // decoded source
);
	if (OPW != 10) begin : g_bad_opw
		$error("npr_decode: opcode width must be 10");
	end
	always_comb begin
		if (!i_vld) begin
			o_sel = npr_pkg::NPR_SEL_NONE;
		end else if (i_op == `NPR_OP_TIMER4) begin
			o_sel = npr_pkg::NPR_SEL_T4;
		end else if (i_op == `NPR_OP_CONV) begin
			o_sel = npr_pkg::NPR_SEL_CONV;
		end else if (i_op == `NPR_OP_HOLD) begin
			o_sel = npr_pkg::NPR_SEL_HOLD;
		end else begin
			o_sel = npr_pkg::NPR_SEL_NONE;
		end
	end
endmodule
`default_nettype wire

// File: hw/npr_core.sv
// execute stage for the timer, converter and holding-register reads
`timescale 1ns/100ps
`default_nettype none
`include "npr_map.svh"
module npr_core #(
	parameter int OPW   = 10, // instruction word width
	parameter int NIBW  = 4,  // width of each nibble register
	parameter int T4W   = 8,  // fourth timer count width
	parameter int RESW  = 10, // converter result width
	parameter int CTLW  = 4,  // converter control register width
	parameter int HOLDW = 8   // holding register width
) (
	input  wire logic             I_CLK,       // 40 MHz instruction clock
	input  wire logic             I_RSTN,      // async reset, active low
	input  wire logic             I_CE,        // clock enable, freezes state when low
	input  wire logic [OPW-1:0]   I_OP,        // instruction word
	input  wire logic             I_OP_VLD,    // instruction executes this cycle
	input  wire logic [T4W-1:0]   I_T4_CNT,    // fourth timer count
	input  wire logic [RESW-1:0]  I_CONV_RES,  // converter result register
	input  wire logic [CTLW-1:0]  I_CONV_CTRL, // converter control register
	input  wire logic [HOLDW-1:0] I_HOLD,      // holding register
	input  wire logic             I_CARRY,     // carry flag in
	output logic                  O_WE,        // write strobe to both nibble registers
	output logic [NIBW-1:0]       O_UPPER,     // upper-nibble register value
	output logic [NIBW-1:0]       O_ACC,       // accumulator value
	output logic                  O_CARRY,     // carry flag out
	output logic                  O_SKIP       // skip next instruction
);
	npr_pkg::npr_sel_t sel;
	npr_pkg::npr_wr_t  pick;
	logic              we_reg;
	logic              we_next;
	logic [NIBW-1:0]   upper_reg;
	logic [NIBW-1:0]   upper_next;
	logic [NIBW-1:0]   acc_reg;
	logic [NIBW-1:0]   acc_next;
	logic              carry_reg;
	logic              carry_next;
	logic              skip_reg;
	logic              skip_next;
	logic              mode_bit;
	logic [NIBW-1:0]   t4_hi;
	logic [NIBW-1:0]   t4_lo;
	logic [NIBW-1:0]   conv_hi;
	logic [NIBW-1:0]   conv_lo;
	logic [NIBW-1:0]   cmp_hi;
	logic [NIBW-1:0]   cmp_lo;
	logic [NIBW-1:0]   hold_hi;
	logic [NIBW-1:0]   hold_lo;
	logic [NIBW-1:0]   res_hi;
	logic [NIBW-1:0]   res_lo;

	// values that the fixed opcodes, field positions and carrier struct cannot serve
	if (OPW != 10) begin : g_bad_opw
		$error("npr_core: opcode width must be 10");
	end
	if (NIBW != 4) begin : g_bad_nibw
		$error("npr_core: nibble width must be 4");
	end
	if (T4W < `NPR_HI_LSB_T4 + NIBW) begin : g_bad_t4w
		$error("npr_core: timer count too narrow for its upper nibble");
	end
	if (`NPR_LO_LSB_T4 + NIBW > `NPR_HI_LSB_T4) begin : g_bad_t4_fields
		$error("npr_core: timer nibbles overlap");
	end
	if (RESW < `NPR_HI_LSB_CONV + NIBW) begin : g_bad_convw
		$error("npr_core: converter result too narrow for conversion mode");
	end
	if (`NPR_LO_LSB_CONV + NIBW > `NPR_HI_LSB_CONV) begin : g_bad_conv_fields
		$error("npr_core: conversion mode nibbles overlap");
	end
	if (RESW < `NPR_HI_LSB_CMP + NIBW) begin : g_bad_cmpw
		$error("npr_core: converter result too narrow for comparator mode");
	end
	if (`NPR_LO_LSB_CMP + NIBW > `NPR_HI_LSB_CMP) begin : g_bad_cmp_fields
		$error("npr_core: comparator mode nibbles overlap");
	end
	if (CTLW <= `NPR_MODE_BIT) begin : g_bad_ctlw
		$error("npr_core: control register lacks the mode bit");
	end
	if (HOLDW < `NPR_HI_LSB_HOLD + NIBW) begin : g_bad_holdw
		$error("npr_core: holding register too narrow for its upper nibble");
	end
	if (`NPR_LO_LSB_HOLD + NIBW > `NPR_HI_LSB_HOLD) begin : g_bad_hold_fields
		$error("npr_core: holding register nibbles overlap");
	end

	npr_decode #(.OPW(OPW)) u_dec (
		.i_op  (I_OP),
		.i_vld (I_OP_VLD),
		.o_sel (sel)
	);

	// field extraction repeats per nibble bit
	for (genvar b = 0; b < NIBW; b++) begin : g_bit
		assign t4_hi[b]   = I_T4_CNT[`NPR_HI_LSB_T4 + b];
		assign t4_lo[b]   = I_T4_CNT[`NPR_LO_LSB_T4 + b];
		assign conv_hi[b] = I_CONV_RES[`NPR_HI_LSB_CONV + b];
		assign conv_lo[b] = I_CONV_RES[`NPR_LO_LSB_CONV + b];
		assign cmp_hi[b]  = I_CONV_RES[`NPR_HI_LSB_CMP + b];
		assign cmp_lo[b]  = I_CONV_RES[`NPR_LO_LSB_CMP + b];
		assign hold_hi[b] = I_HOLD[`NPR_HI_LSB_HOLD + b];
		assign hold_lo[b] = I_HOLD[`NPR_LO_LSB_HOLD + b];
	end

	assign mode_bit = I_CONV_CTRL[`NPR_MODE_BIT];

	// mode bit is read in the executing cycle; no earlier copy is kept
	always_comb begin
		if (!mode_bit) begin
			res_hi = conv_hi;
			res_lo = conv_lo;
		end else begin
			res_hi = cmp_hi;
			res_lo = cmp_lo;
		end
	end

	// source pair chosen by the decoded opcode
	always_comb begin
		pick = '0;
		case (sel)
			npr_pkg::NPR_SEL_T4: begin
				pick.we    = 1'b1;
				pick.upper = t4_hi;
				pick.acc   = t4_lo;
			end
			npr_pkg::NPR_SEL_CONV: begin
				pick.we    = 1'b1;
				pick.upper = res_hi;
				pick.acc   = res_lo;
			end
			npr_pkg::NPR_SEL_HOLD: begin
				pick.we    = 1'b1;
				pick.upper = hold_hi;
				pick.acc   = hold_lo;
			end
			default: begin
				pick.we = 1'b0;
			end
		endcase
	end

	// write strobe lasts one enabled cycle
	always_comb begin
		we_next = pick.we;
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			we_reg <= 1'b0;
		end else if (I_CE) begin
			we_reg <= we_next;
		end
	end

	// upper-nibble register: loaded by any of the three reads, held otherwise
	always_comb begin
		if (pick.we) begin
			upper_next = pick.upper;
		end else begin
			upper_next = upper_reg;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			upper_reg <= `NPR_NIB_RESET;
		end else if (I_CE) begin
			upper_reg <= upper_next;
		end
	end

	// accumulator: loaded together with the upper nibble, held otherwise
	always_comb begin
		if (pick.we) begin
			acc_next = pick.acc;
		end else begin
			acc_next = acc_reg;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			acc_reg <= `NPR_NIB_RESET;
		end else if (I_CE) begin
			acc_reg <= acc_next;
		end
	end

	// carry is registered unchanged from I_CARRY one enabled cycle later; none of these reads touch it
	always_comb begin
		carry_next = I_CARRY;
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			carry_reg <= 1'b0;
		end else if (I_CE) begin
			carry_reg <= carry_next;
		end
	end

	// no read here ever skips the next instruction
	always_comb begin
		skip_next = 1'b0;
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			skip_reg <= 1'b0;
		end else if (I_CE) begin
			skip_reg <= skip_next;
		end
	end

	always_comb begin
		O_WE    = we_reg;
		O_UPPER = upper_reg;
		O_ACC   = acc_reg;
		O_CARRY = carry_reg;
		O_SKIP  = skip_reg;
	end
endmodule
`default_nettype wire

// File: tb/npr_props.sv
// concurrent checks on the nibble pair read core ports
`timescale 1ns/100ps
`default_nettype none
module npr_props (
	input wire logic       I_CLK,       // clock
	input wire logic       I_RSTN,      // reset, active low
	input wire logic       I_CE,        // enable
	input wire logic [9:0] I_OP,        // word
	input wire logic       I_OP_VLD,    // valid
	input wire logic [7:0] I_T4_CNT,    // timer count
	input wire logic [9:0] I_CONV_RES,  // result
	input wire logic [3:0] I_CONV_CTRL, // control
	input wire logic [7:0] I_HOLD,      // holding
	input wire logic       I_CARRY,     // carry in
	input wire logic       O_WE,        // write
	input wire logic [3:0] O_UPPER,     // upper
	input wire logic [3:0] O_ACC,       // acc
	input wire logic       O_CARRY,     // carry out
	input wire logic       O_SKIP       // skip
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RSTN);
	wire go = I_CE && I_OP_VLD;
	wire t4 = go && I_OP == 10'h273;
	wire cv = go && I_OP == 10'h279;
	wire hd = go && I_OP == 10'h02a;
	chk_t4_upper: assert property (t4 |=> O_WE && O_UPPER == $past(I_T4_CNT[7:4]))
		else $error("timer upper nibble wrong");
	chk_t4_acc: assert property (t4 |=> O_ACC == $past(I_T4_CNT[3:0]))
		else $error("timer low nibble wrong");
	chk_conv_mode0: assert property (cv && !I_CONV_CTRL[3] |=> {O_UPPER, O_ACC} == $past(I_CONV_RES[9:2]))
		else $error("conversion mode pair wrong");
	chk_conv_mode1: assert property (cv && I_CONV_CTRL[3] |=> {O_UPPER, O_ACC} == $past(I_CONV_RES[7:0]))
		else $error("comparator mode pair wrong");
	chk_hold_upper: assert property (hd |=> O_WE && O_UPPER == $past(I_HOLD[7:4]))
		else $error("holding upper nibble wrong");
	chk_hold_acc: assert property (hd |=> O_ACC == $past(I_HOLD[3:0]))
		else $error("holding low nibble wrong");
	chk_other_held: assert property (I_CE && !(t4 || cv || hd) |=> !O_WE && $stable(O_UPPER) && $stable(O_ACC))
		else $error("write without a read opcode");
	chk_carry_kept: assert property (I_CE |=> O_CARRY == $past(I_CARRY) && !O_SKIP)
		else $error("carry altered or skip raised");
endmodule
bind npr_core npr_props u_props (
	.I_CLK       (I_CLK),
	.I_RSTN      (I_RSTN),
	.I_CE        (I_CE),
	.I_OP        (I_OP),
	.I_OP_VLD    (I_OP_VLD),
	.I_T4_CNT    (I_T4_CNT),
	.I_CONV_RES  (I_CONV_RES),
	.I_CONV_CTRL (I_CONV_CTRL),
	.I_HOLD      (I_HOLD),
	.I_CARRY     (I_CARRY),
	.O_WE        (O_WE),
	.O_UPPER     (O_UPPER),
	.O_ACC       (O_ACC),
	.O_CARRY     (O_CARRY),
	.O_SKIP      (O_SKIP)
);
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the nibble pair read core
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench;
	logic       I_CLK = 0, I_RSTN = 0, I_CE = 0, I_OP_VLD = 0, I_CARRY = 0;
	logic [9:0] I_OP = 0, I_CONV_RES = 0;
	logic [7:0] I_T4_CNT = 0, I_HOLD = 0, src;
	logic [3:0] I_CONV_CTRL = 0, O_UPPER, O_ACC, up = 0, ac = 0;
	logic       O_WE, O_CARRY, O_SKIP, we = 0, cy = 0;
	int         compares = 0, miscompares = 0, seed = 13948, n, expv;
	int         exp_q [$];
	logic [9:0] ops [4] = '{10'h273, 10'h279, 10'h02a, 10'h275};
	always #12.5 I_CLK = ~I_CLK;
	npr_core dut_u (
		.I_CLK       (I_CLK),
		.I_RSTN      (I_RSTN),
		.I_CE        (I_CE),
		.I_OP        (I_OP),
		.I_OP_VLD    (I_OP_VLD),
		.I_T4_CNT    (I_T4_CNT),
		.I_CONV_RES  (I_CONV_RES),
		.I_CONV_CTRL (I_CONV_CTRL),
		.I_HOLD      (I_HOLD),
		.I_CARRY     (I_CARRY),
		.O_WE        (O_WE),
		.O_UPPER     (O_UPPER),
		.O_ACC       (O_ACC),
		.O_CARRY     (O_CARRY),
		.O_SKIP      (O_SKIP)
	);
	task results;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#(25 * 800);
		miscompares++;
		results;
	end
	initial begin
		repeat (2) @(posedge I_CLK);
		`CHK("reset", 10'h0, {O_WE, O_UPPER, O_ACC, O_CARRY})
		#2 I_RSTN = 1;
		for (n = 0; n < 400; n++) begin
			{I_T4_CNT, I_HOLD, I_CONV_RES, I_CONV_CTRL, I_CARRY, I_OP_VLD} = $random(seed);
			I_OP = ops[$random(seed) & 3];
			I_CE = (n % 23) != 5;
			if (I_CE) begin
				we = I_OP_VLD && I_OP != 10'h275;
				cy = I_CARRY;
			end
			src = I_OP == 10'h273 ? I_T4_CNT : I_OP == 10'h02a ? I_HOLD :
				I_CONV_CTRL[3] ? I_CONV_RES[7:0] : I_CONV_RES[9:2];
			if (I_CE && we) {up, ac} = src;
			exp_q.push_back(int'({we, up, ac, cy}));
			@(posedge I_CLK);
			#2;
			expv = exp_q.pop_front();
			`CHK("write", expv[9], O_WE)
			`CHK("upper", expv[8:5], O_UPPER)
			`CHK("acc", expv[4:1], O_ACC)
			`CHK("carry skip", {expv[0], 1'b0}, {O_CARRY, O_SKIP})
		end
		$display("random read test done");
		I_RSTN = 0;
		{we, up, ac, cy} = 10'h0;
		@(posedge I_CLK);
		#2;
		`CHK("reset again", 10'h0, {O_WE, O_UPPER, O_ACC, O_CARRY})
		I_RSTN = 1;
		{I_CE, I_OP_VLD, I_OP, I_HOLD} = {2'b11, 10'h02a, 8'ha5};
		@(posedge I_CLK);
		#2;
		`CHK("hold walk", {1'b1, 8'ha5}, {O_WE, O_UPPER, O_ACC})
		I_OP_VLD = 0;
		@(posedge I_CLK);
		#2;
		`CHK("strobe drop", 9'h0a5, {O_WE, O_UPPER, O_ACC})
		$display("reset and walk test done");
		results;
	end
endmodule
`default_nettype wire
